/* File: pps_pkg.sv */
// Package: register map, field positions and carriers of the printer port
package pps_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] PPS_DATA_ADDR = 12'h000;
    localparam logic [11:0] PPS_STAT_ADDR = 12'h004;
    localparam logic [11:0] PPS_CTRL_ADDR = 12'h008;
    localparam logic [11:0] PPS_ISTS_ADDR = 12'h00C;
    localparam logic [11:0] PPS_IMSK_ADDR = 12'h010;
    localparam logic [11:0] PPS_DDIR_ADDR = 12'h014;
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int PPS_CTRL_STB = 0;
    localparam int PPS_CTRL_AFD = 1;
    localparam int PPS_CTRL_INI = 2;
    localparam int PPS_CTRL_SEL = 3;
    localparam int PPS_CTRL_IEN = 4;
    localparam int PPS_CTRL_W = 5;
    localparam logic [4:0] PPS_CTRL_RST = 5'h04;
    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int PPS_STAT_ERR = 3;
    localparam int PPS_STAT_SLC = 4;
    localparam int PPS_STAT_PE = 5;
    localparam int PPS_STAT_ACK = 6;
    localparam int PPS_STAT_BSY = 7;
    // ----------------------------------------------------------------
    // Event bits (interrupt status and mask)
    // ----------------------------------------------------------------
    localparam int PPS_EV_ACK = 0;
    localparam int PPS_EV_FLT = 1;
    localparam int PPS_EV_PE = 2;
    localparam int PPS_EV_W = 3;
    localparam logic [2:0] PPS_EV_RST = 3'h0;
    localparam logic [7:0] PPS_DATA_RST = 8'h00;
    localparam logic [31:0] PPS_ZERO32 = 32'h0000_0000;
    localparam int PPS_SYNC_STAGES = 3;
    // Status synchroniser starts at an idle printer's levels, so the
    // event edge detectors see no false edge when reset is released
    localparam logic [4:0] PPS_STAT_IDLE = 5'h0B;

    // Printer status inputs grouped together
    typedef struct packed {
        logic busy;
        logic took_byte_n;
        logic media_out;
        logic online;
        logic fault_n;
    } pps_status_t;

    // Printer control outputs grouped together
    typedef struct packed {
        logic choose_n;
        logic setup_n;
        logic line_advance_n;
        logic latch_pulse_n;
    } pps_ctrl_pins_t;
endpackage : pps_pkg

/* File: pps_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pps_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_next;

    // A zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("pps_sync needs WIDTH of at least one");
    end

    // A bit moves only once stages two and three agree
    assign q_next = (s2_reg & s3_reg) | (q_out & (s2_reg | s3_reg));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_out <= q_next;
        end
    end
endmodule : pps_sync

/* File: pps_port.sv */
// Standard printer port: APB registers, control pins, status, interrupt
`timescale 1ns/100ps
module pps_port
    import pps_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_data_bus_in,
    output logic [7:0] port_data_bus_out,
    output logic port_data_bus_oe,
    output logic printer_choose_n,
    output logic printer_setup_n,
    output logic line_advance_n,
    output logic byte_latch_pulse_n,
    input wire logic printer_busy,
    input wire logic printer_took_byte_n,
    input wire logic media_out,
    input wire logic printer_online,
    input wire logic printer_fault_n,
    output logic port_irq_out
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] data_reg;
    logic [PPS_CTRL_W-1:0] ctrl_reg;
    logic [PPS_EV_W-1:0] ists_reg;
    logic [PPS_EV_W-1:0] imsk_reg;
    logic ddir_reg;
    logic [PPS_EV_W-1:0] ev_prev_reg;
    pps_ctrl_pins_t pins_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] dout_reg;
    logic doe_reg;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    pps_status_t st_raw;
    pps_status_t st_sync;
    logic [7:0] din_sync;

    assign st_raw = '{busy: printer_busy, took_byte_n: printer_took_byte_n,
                      media_out: media_out, online: printer_online,
                      fault_n: printer_fault_n};

    pps_sync #(
        .WIDTH($bits(pps_status_t)),
        .RST_VAL(PPS_STAT_IDLE)
    ) u_st_sync (
        .clk(clk),
        .rstn(rstn),
        .d_in(st_raw),
        .q_out(st_sync)
    );

    pps_sync #(.WIDTH(8), .RST_VAL(PPS_DATA_RST)) u_din_sync (
        .clk(clk),
        .rstn(rstn),
        .d_in(port_data_bus_in),
        .q_out(din_sync)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable && !pready_reg;
    wire wr_en = access_ph && pwrite;
    wire rd_en = access_ph && !pwrite;
    wire hit_data = (paddr == PPS_DATA_ADDR);
    wire hit_stat = (paddr == PPS_STAT_ADDR);
    wire hit_ctrl = (paddr == PPS_CTRL_ADDR);
    wire hit_ists = (paddr == PPS_ISTS_ADDR);
    wire hit_imsk = (paddr == PPS_IMSK_ADDR);
    wire hit_ddir = (paddr == PPS_DDIR_ADDR);
    wire hit_any = hit_data | hit_stat | hit_ctrl | hit_ists | hit_imsk
                   | hit_ddir;

    // ----------------------------------------------------------------
    // Status byte
    // ----------------------------------------------------------------
    logic [7:0] stat_byte;
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[PPS_STAT_BSY] = ~st_sync.busy;
        stat_byte[PPS_STAT_ACK] = st_sync.took_byte_n;
        stat_byte[PPS_STAT_PE] = st_sync.media_out;
        stat_byte[PPS_STAT_SLC] = st_sync.online;
        stat_byte[PPS_STAT_ERR] = st_sync.fault_n;
    end

    // ----------------------------------------------------------------
    // Events: acknowledge falls, fault falls, media out rises
    // ----------------------------------------------------------------
    logic [PPS_EV_W-1:0] ev_lvl;
    always_comb begin
        ev_lvl = '0;
        ev_lvl[PPS_EV_ACK] = ~st_sync.took_byte_n;
        ev_lvl[PPS_EV_FLT] = ~st_sync.fault_n;
        ev_lvl[PPS_EV_PE] = st_sync.media_out;
    end
    wire [PPS_EV_W-1:0] ev_rise = ev_lvl & ~ev_prev_reg;
    wire ists_rd = rd_en && hit_ists;
    // Set wins over the read clear so no event is lost
    wire [PPS_EV_W-1:0] ists_next = (ists_rd ? PPS_EV_RST : ists_reg)
                                    | ev_rise;
    // Port interrupt request, gated by control bit 4
    wire irq_next = ctrl_reg[PPS_CTRL_IEN]
                    && |(ists_next & imsk_reg);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = PPS_ZERO32;
        unique case (1'b1)
            hit_data: rd_word[7:0] = ddir_reg ? din_sync : data_reg;
            hit_stat: rd_word[7:0] = stat_byte;
            hit_ctrl: rd_word[PPS_CTRL_W-1:0] = ctrl_reg;
            hit_ists: rd_word[PPS_EV_W-1:0] = ists_reg;
            hit_imsk: rd_word[PPS_EV_W-1:0] = imsk_reg;
            hit_ddir: rd_word[0] = ddir_reg;
            default: rd_word = PPS_ZERO32;
        endcase
    end

    // Pin values from the control register
    pps_ctrl_pins_t pins_next;
    assign pins_next.choose_n = ~ctrl_reg[PPS_CTRL_SEL];
    assign pins_next.setup_n = ctrl_reg[PPS_CTRL_INI];
    assign pins_next.line_advance_n = ~ctrl_reg[PPS_CTRL_AFD];
    // Software raises bit 0 then clears it; the pin pulses low between
    assign pins_next.latch_pulse_n = ~ctrl_reg[PPS_CTRL_STB];

    // ----------------------------------------------------------------
    // Registers written by software
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_reg <= PPS_DATA_RST;
            ctrl_reg <= PPS_CTRL_RST;
            imsk_reg <= PPS_EV_RST;
            ddir_reg <= 1'b0;
        end else if (wr_en) begin
            if (hit_data) data_reg <= pwdata[7:0];
            if (hit_ctrl) ctrl_reg <= pwdata[PPS_CTRL_W-1:0];
            if (hit_imsk) imsk_reg <= pwdata[PPS_EV_W-1:0];
            if (hit_ddir) ddir_reg <= pwdata[0];
        end
    end

    // ----------------------------------------------------------------
    // Event and output flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ists_reg <= PPS_EV_RST;
            ev_prev_reg <= PPS_EV_RST;
            irq_reg <= 1'b0;
            pins_reg <= '1;
            dout_reg <= PPS_DATA_RST;
            doe_reg <= 1'b0;
        end else begin
            ists_reg <= ists_next;
            ev_prev_reg <= ev_lvl;
            irq_reg <= irq_next;
            pins_reg <= pins_next;
            dout_reg <= data_reg;
            doe_reg <= ~ddir_reg;
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one wait state in each access phase
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_reg <= PPS_ZERO32;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= access_ph;
            pslverr_reg <= access_ph && !hit_any;
            if (rd_en) prdata_reg <= rd_word;
            else if (setup_ph) prdata_reg <= PPS_ZERO32;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign port_data_bus_out = dout_reg;
    assign port_data_bus_oe = doe_reg;
    assign printer_choose_n = pins_reg.choose_n;
    assign printer_setup_n = pins_reg.setup_n;
    assign line_advance_n = pins_reg.line_advance_n;
    assign byte_latch_pulse_n = pins_reg.latch_pulse_n;
    assign port_irq_out = irq_reg;
endmodule : pps_port

/* File: pps_port_monitor.sv */
// Checker of pin, status and interrupt relations of the printer port
`timescale 1ns/100ps
module pps_port_monitor
    import pps_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] port_data_bus_in,
    input wire logic [7:0] port_data_bus_out,
    input wire logic port_data_bus_oe,
    input wire logic printer_choose_n,
    input wire logic printer_setup_n,
    input wire logic line_advance_n,
    input wire logic byte_latch_pulse_n,
    input wire logic printer_busy,
    input wire logic printer_took_byte_n,
    input wire logic media_out,
    input wire logic printer_online,
    input wire logic printer_fault_n,
    input wire logic port_irq_out
);
    // ------
    // Shadows of written registers
    // ------
    logic [4:0] ctl_reg;
    logic [7:0] dat_reg;
    logic [1:0] cage_reg;
    logic [1:0] dage_reg;
    logic [2:0] stab_reg;
    logic [4:0] pins_reg;
    wire done = psel && penable && pready;
    wire ctl_wr = done && pwrite && paddr == PPS_CTRL_ADDR;
    wire dat_wr = done && pwrite && paddr == PPS_DATA_ADDR;
    wire stat_rd = done && !pwrite && paddr == PPS_STAT_ADDR;
    wire [4:0] pins = {printer_busy, printer_took_byte_n, media_out,
        printer_online, printer_fault_n};
    wire [1:0] cage_next = ctl_wr ? 2'h0 : cage_reg + 2'(cage_reg != 2'h2);
    wire [1:0] dage_next = dat_wr ? 2'h0 : dage_reg + 2'(dage_reg != 2'h2);
    // Inputs pass a synchroniser, so status is trusted only once steady
    wire [2:0] stab_next = (pins != pins_reg) ? 3'h0 :
        stab_reg + 3'(stab_reg != 3'h7);
    always_ff @(posedge clk) begin
        pins_reg <= pins;
        if (!rstn) begin
            ctl_reg <= PPS_CTRL_RST;
            dat_reg <= PPS_DATA_RST;
            cage_reg <= 2'h0;
            dage_reg <= 2'h0;
            stab_reg <= 3'h0;
        end else begin
            ctl_reg <= ctl_wr ? pwdata[4:0] : ctl_reg;
            dat_reg <= dat_wr ? pwdata[7:0] : dat_reg;
            cage_reg <= cage_next;
            dage_reg <= dage_next;
            stab_reg <= stab_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_ctl_settled;
        cage_reg == 2'h2;
    endsequence
    sequence s_stb_set;
        ctl_wr && pwdata[PPS_CTRL_STB];
    endsequence
    sequence s_stat_steady;
        stat_rd && stab_reg == 3'h7;
    endsequence
    a_choose_pin: assert property (s_ctl_settled |->
        printer_choose_n == !ctl_reg[3]) else $error("choose pin wrong");
    a_setup_pin: assert property (s_ctl_settled |->
        printer_setup_n == ctl_reg[2]) else $error("setup pin wrong");
    a_feed_pin: assert property (s_ctl_settled |->
        line_advance_n == !ctl_reg[1]) else $error("feed pin wrong");
    a_strobe_pin: assert property (s_ctl_settled |->
        byte_latch_pulse_n == !ctl_reg[0]) else $error("strobe pin wrong");
    a_strobe_pulse: assert property (s_stb_set |->
        ##[1:3] !byte_latch_pulse_n) else $error("strobe not low");
    a_irq_gate: assert property (!ctl_reg[4] &&
        cage_reg == 2'h2 |-> !port_irq_out) else $error("interrupt not gated");
    a_data_hold: assert property (dage_reg == 2'h2 |->
        port_data_bus_out == dat_reg) else $error("data bus wrong");
    a_busy_read: assert property (s_stat_steady |->
        prdata[7] == !printer_busy) else $error("busy bit wrong");
    a_stat_read: assert property (
        s_stat_steady |-> prdata[6:3] == pins[3:0])
        else $error("status bits wrong");
endmodule : pps_port_monitor
bind pps_port pps_port_monitor u_mon (.*);

/* File: pps_printer_model.sv */
// Printer model on the far side of the port cable
`timescale 1ns/100ps
module pps_printer_model (
    input wire logic clk,
    input wire logic byte_latch_pulse_n,
    input wire logic [7:0] port_data_bus_out,
    input wire logic port_data_bus_oe,
    input wire logic pm_paper_gone,
    input wire logic pm_power,
    input wire logic pm_fault,
    output logic [7:0] port_data_bus_in,
    output logic [7:0] pm_byte,
    output logic printer_busy,
    output logic printer_took_byte_n,
    output logic media_out,
    output logic printer_online,
    output logic printer_fault_n
);
    logic stb_q = 1'b1;
    logic work = 1'b0;
    int cnt = 0;
    // Printer answers with its own byte once the port lets go
    assign port_data_bus_in = port_data_bus_oe ?
        port_data_bus_out : 8'h3C;
    assign printer_busy = work || pm_paper_gone;
    assign media_out = pm_paper_gone;
    assign printer_online = pm_power;
    assign printer_fault_n = !pm_fault;
    initial pm_byte = 8'h00;
    initial printer_took_byte_n = 1'b1;
    always @(posedge clk) begin
        stb_q <= byte_latch_pulse_n;
        if (stb_q && !byte_latch_pulse_n) begin
            pm_byte <= port_data_bus_out;
            work <= 1'b1;
            cnt <= 8;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            work <= cnt > 4;
            printer_took_byte_n <= !(cnt inside {[2:4]});
        end
    end
endmodule : pps_printer_model

/* File: pps_port_tb.sv */
// Testbench of the printer port over its register bus
`timescale 1ns/100ps
module pps_port_tb;
    import pps_pkg::*;
    logic clk = 0;
    logic rstn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, port_data_bus_oe, port_irq_out;
    logic [7:0] port_data_bus_in, port_data_bus_out, pm_byte;
    logic printer_choose_n, printer_setup_n, line_advance_n;
    logic byte_latch_pulse_n, printer_busy, printer_took_byte_n;
    logic media_out, printer_online, printer_fault_n;
    logic pm_paper_gone = 0, pm_power = 1, pm_fault = 0;
    int fail_count = 0;
    int total_checks = 0;
    wire [3:0] ctl_pins = {printer_choose_n, printer_setup_n,
        line_advance_n, byte_latch_pulse_n};
    always #50 clk = ~clk;
    pps_port u_dut (.*);
    pps_printer_model u_prn (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check(pready, 1'b1);
        if (pready !== 1'b1) summarize();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ------
    // Main sequence
    // ------
    initial begin
        tick(8);
        rstn <= 1'b1;
        apb(0, PPS_CTRL_ADDR, 0);
        check(rd, 32'h0000_0004);
        check(ctl_pins, 4'hF);
        for (int i = 0; i < 16; i++) begin
            apb(1, PPS_CTRL_ADDR, i);
            tick(3);
            check(ctl_pins[3:2], i[3:2] ^ 2'h2);
            check(ctl_pins[1:0], i[1:0] ^ 2'h3);
        end
        $display("test control pins done");
        apb(1, PPS_CTRL_ADDR, 32'h0000_0004);
        apb(1, PPS_DATA_ADDR, 32'h0000_00A5);
        apb(1, PPS_CTRL_ADDR, 32'h0000_0005);
        apb(1, PPS_CTRL_ADDR, 32'h0000_0004);
        tick(12);
        check(pm_byte, 8'hA5);
        check(port_data_bus_out, 8'hA5);
        check(port_data_bus_oe, 1'b1);
        apb(1, PPS_DDIR_ADDR, 1);
        tick(8);
        apb(0, PPS_DATA_ADDR, 0);
        check(rd, 32'h0000_003C);
        check(port_data_bus_oe, 1'b0);
        apb(1, PPS_DDIR_ADDR, 0);
        $display("test data strobe done");
        for (int k = 0; k < 4; k++) begin
            pm_paper_gone <= k[0];
            pm_power <= !k[0];
            pm_fault <= k[1];
            tick(10);
            apb(0, PPS_STAT_ADDR, 0);
            check(rd[7], !k[0]);
            check(rd[6:3], {1'b1, k[0], !k[0], !k[1]});
        end
        pm_paper_gone <= 1'b0;
        pm_power <= 1'b1;
        pm_fault <= 1'b0;
        $display("test status done");
        tick(10);
        apb(0, PPS_ISTS_ADDR, 0);
        apb(0, PPS_ISTS_ADDR, 0);
        check(rd, 32'h0000_0000);
        apb(1, PPS_IMSK_ADDR, 32'h0000_0001);
        apb(1, PPS_CTRL_ADDR, 32'h0000_0005);
        apb(1, PPS_CTRL_ADDR, 32'h0000_0004);
        tick(16);
        check(port_irq_out, 1'b0);
        apb(1, PPS_CTRL_ADDR, 32'h0000_0014);
        tick(2);
        check(port_irq_out, 1'b1);
        apb(1, PPS_IMSK_ADDR, 0);
        tick(2);
        check(port_irq_out, 1'b0);
        apb(1, PPS_IMSK_ADDR, 1);
        apb(0, PPS_ISTS_ADDR, 0);
        check(rd, 32'h0000_0001);
        tick(2);
        check(port_irq_out, 1'b0);
        apb(0, 12'h020, 0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        $display("test interrupt done");
        summarize();
    end
endmodule : pps_port_tb
